// ### verilog/agc_cfg_pkg.sv
// Shared constants, field layout and settings record for the gain and carrier-sense configuration.
package agc_cfg_pkg;

    // Register addresses on the serial control port.
    localparam logic [5:0] GAIN_LIMIT_TARGET_ADDR = 6'h1B;
    localparam logic [5:0] PRIORITY_SENSE_ADDR = 6'h1C;

    // Values after reset.
    localparam logic [7:0] GAIN_LIMIT_TARGET_RESET = 8'h03;
    localparam logic [6:0] PRIORITY_SENSE_RESET = 7'h40;

    // Field positions in the gain-limit and target register.
    localparam int DGAIN_LIMIT_LSB = 6;
    localparam int FE_CAP_LSB = 3;
    localparam int TARGET_LSB = 0;

    // Field positions in the priority and carrier-sense register.
    localparam int ORDER_BIT = 6;
    localparam int REL_THR_LSB = 4;
    localparam int ABS_THR_LSB = 0;

    // Index of the highest digital gain step that the loop may pick; a plain default.
    localparam logic [2:0] DIGITAL_GAIN_TOP_STEP = 3'h7;

    // Absolute threshold code that switches absolute sensing off.
    localparam logic [3:0] ABS_THR_OFF_CODE = 4'h8;

    // Decoded settings handed to the receive path.
    typedef struct packed {
        logic [2:0] dgain_step_max;
        logic [7:0] fe_cap_tenth_db;
        logic [6:0] target_db;
        logic reduce_first_amp_first;
        logic rel_enable;
        logic [3:0] rel_db;
        logic abs_enable;
        logic [6:0] abs_db;
    } settings_type;

    // Amplitude target in dB for a target code.
    function automatic logic [6:0] target_db_of(input logic [2:0] code);
        logic [6:0] db;
        db = 7'h18;
        unique case (code)
            3'h0: db = 7'h18;
            3'h1: db = 7'h1B;
            3'h2: db = 7'h1E;
            3'h3: db = 7'h21;
            3'h4: db = 7'h24;
            3'h5: db = 7'h26;
            3'h6: db = 7'h28;
            3'h7: db = 7'h2A;
        endcase
        return db;
    endfunction : target_db_of

    // Front-end gain reduction below maximum, in tenths of a dB.
    function automatic logic [7:0] fe_cap_of(input logic [2:0] code);
        logic [7:0] tenth;
        tenth = 8'h00;
        unique case (code)
            3'h0: tenth = 8'h00;
            3'h1: tenth = 8'h1A;
            3'h2: tenth = 8'h3D;
            3'h3: tenth = 8'h4A;
            3'h4: tenth = 8'h5C;
            3'h5: tenth = 8'h73;
            3'h6: tenth = 8'h92;
            3'h7: tenth = 8'hAB;
        endcase
        return tenth;
    endfunction : fe_cap_of

    // Relative rise threshold in dB.
    function automatic logic [3:0] rel_db_of(input logic [1:0] code);
        logic [3:0] db;
        db = 4'h0;
        unique case (code)
            2'h0: db = 4'h0;
            2'h1: db = 4'h6;
            2'h2: db = 4'hA;
            2'h3: db = 4'hE;
        endcase
        return db;
    endfunction : rel_db_of

    // Absolute threshold in dB: target plus a signed offset.
    function automatic logic [6:0] abs_db_of(input logic [2:0] target, input logic [3:0] offset);
        return 7'(target_db_of(target) + {{3{offset[3]}}, offset});
    endfunction : abs_db_of

endpackage : agc_cfg_pkg

// ### verilog/carrier_sense_detect.sv
// Carrier-sense decision from the uncompensated amplitude and the signal-strength rise.
`timescale 1ns/1ps
module carrier_sense_detect (
    input wire logic clk,
    input wire logic resetn,
    input wire agc_cfg_pkg::settings_type settings,
    input wire logic [6:0] filter_amp_db,
    input wire logic [6:0] gain_reduction_db,
    input wire logic [6:0] strength_rise_db,
    output logic carrier_sense
);
    import agc_cfg_pkg::*;

    logic [7:0] raw_amp_db;
    logic abs_hit;
    logic rel_hit;

    // The loop's own gain cut is added back so the threshold sees the raw input level.
    assign raw_amp_db = {1'h0, filter_amp_db} + {1'h0, gain_reduction_db};
    assign abs_hit = settings.abs_enable && (raw_amp_db >= {1'b0, settings.abs_db});
    assign rel_hit = settings.rel_enable && (strength_rise_db >= {3'h0, settings.rel_db});

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            carrier_sense <= 1'h0;
        end else begin
            carrier_sense <= abs_hit || rel_hit;
        end
    end

    a_rel_off_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (!settings.rel_enable && !settings.abs_enable) |=> !carrier_sense)
        else $error("Carrier sense raised with both thresholds off.");

    a_abs_uses_raw: assert property (@(posedge clk) disable iff (!resetn)
        (settings.abs_enable && ({1'h0, filter_amp_db} + {1'h0, gain_reduction_db} >= {1'h0, settings.abs_db}))
        |=> carrier_sense)
        else $error("Raw amplitude above absolute threshold did not raise carrier sense.");

endmodule : carrier_sense_detect

// ### verilog/agc_gain_limit_carrier_sense_cfg.sv
// Gain-limit, amplitude-target and carrier-sense configuration registers with decoded settings.
`timescale 1ns/1ps
module agc_gain_limit_carrier_sense_cfg (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_write,
    input wire logic cfg_read,
    output logic [7:0] cfg_rdata,
    input wire logic [6:0] filter_amp_db,
    input wire logic [6:0] gain_reduction_db,
    input wire logic [6:0] strength_rise_db,
    output agc_cfg_pkg::settings_type settings,
    output logic carrier_sense
);
    import agc_cfg_pkg::*;

    logic [7:0] limit_target_reg;
    logic [6:0] priority_sense_reg;
    logic [1:0] dgain_limit;
    logic [2:0] fe_cap_code;
    logic [2:0] target_code;
    logic [1:0] rel_code;
    logic [3:0] abs_code;
    settings_type settings_next;

    assign dgain_limit = limit_target_reg[DGAIN_LIMIT_LSB +: 2];
    assign fe_cap_code = limit_target_reg[FE_CAP_LSB +: 3];
    assign target_code = limit_target_reg[TARGET_LSB +: 3];
    assign rel_code = priority_sense_reg[REL_THR_LSB +: 2];
    assign abs_code = priority_sense_reg[ABS_THR_LSB +: 4];

    // Register writes; the unused top bit of the sense register has no storage at all.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            limit_target_reg <= GAIN_LIMIT_TARGET_RESET;
            priority_sense_reg <= PRIORITY_SENSE_RESET;
        end else if (cfg_write) begin
            if (cfg_addr == GAIN_LIMIT_TARGET_ADDR) begin
                limit_target_reg <= cfg_wdata;
            end
            if (cfg_addr == PRIORITY_SENSE_ADDR) begin
                priority_sense_reg <= cfg_wdata[6:0];
            end
        end
    end

    // Read data is held until the next read; unmapped addresses return zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_read) begin
            if (cfg_addr == GAIN_LIMIT_TARGET_ADDR) begin
                cfg_rdata <= limit_target_reg;
            end else if (cfg_addr == PRIORITY_SENSE_ADDR) begin
                cfg_rdata <= {1'h0, priority_sense_reg};
            end else begin
                cfg_rdata <= 8'h00;
            end
        end
    end

    always_comb begin
        settings_next = '0;
        settings_next.dgain_step_max = DIGITAL_GAIN_TOP_STEP - {1'h0, dgain_limit};
        settings_next.fe_cap_tenth_db = fe_cap_of(fe_cap_code);
        settings_next.target_db = target_db_of(target_code);
        settings_next.reduce_first_amp_first = priority_sense_reg[ORDER_BIT];
        settings_next.rel_enable = (rel_code != 2'h0);
        settings_next.rel_db = rel_db_of(rel_code);
        settings_next.abs_enable = (abs_code != ABS_THR_OFF_CODE);
        settings_next.abs_db = abs_db_of(target_code, abs_code);
    end

    // Settings are registered so the receive path sees glitch-free values one cycle after a write lands.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settings <= '0;
        end else begin
            settings <= settings_next;
        end
    end

    carrier_sense_detect sense_unit (
        .clk(clk),
        .resetn(resetn),
        .settings(settings),
        .filter_amp_db(filter_amp_db),
        .gain_reduction_db(gain_reduction_db),
        .strength_rise_db(strength_rise_db),
        .carrier_sense(carrier_sense)
    );

    a_step_limit: assert property (@(posedge clk) disable iff (!resetn)
        1'h1 |=> (settings.dgain_step_max == DIGITAL_GAIN_TOP_STEP - {1'h0, $past(dgain_limit)}))
        else $error("Digital step ceiling does not follow the limit field.");

    a_all_steps_free: assert property (@(posedge clk) disable iff (!resetn)
        (dgain_limit == 2'h0) |=> (settings.dgain_step_max == DIGITAL_GAIN_TOP_STEP))
        else $error("Zero limit did not free every digital step.");

    a_fe_cap_table: assert property (@(posedge clk) disable iff (!resetn)
        (fe_cap_code == 3'h7) |=> (settings.fe_cap_tenth_db == 8'hAB))
        else $error("Largest front-end cap code gives wrong reduction.");

    a_fe_full_gain: assert property (@(posedge clk) disable iff (!resetn)
        (fe_cap_code == 3'h0) |=> (settings.fe_cap_tenth_db == 8'h00))
        else $error("Cap code zero does not allow full front-end gain.");

    a_target_table: assert property (@(posedge clk) disable iff (!resetn)
        (target_code == 3'h5) |=> (settings.target_db == 7'h26))
        else $error("Target code five is not 38 dB.");

    a_target_write: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_write && cfg_addr == GAIN_LIMIT_TARGET_ADDR) |=> ##1
        (settings.target_db == target_db_of($past(cfg_wdata[2:0], 2))))
        else $error("Written target did not reach the settings two cycles later.");

    a_order_bit: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_write && cfg_addr == PRIORITY_SENSE_ADDR) |=> ##1
        (settings.reduce_first_amp_first == $past(cfg_wdata[6], 2)))
        else $error("Amplifier order bit not taken from the write.");

    a_rel_table: assert property (@(posedge clk) disable iff (!resetn)
        (rel_code == 2'h2) |=> (settings.rel_enable && settings.rel_db == 4'hA))
        else $error("Relative code two is not a 10 dB rise.");

    a_abs_disable: assert property (@(posedge clk) disable iff (!resetn)
        (abs_code == ABS_THR_OFF_CODE) |=> !settings.abs_enable)
        else $error("Absolute code -8 left absolute sensing on.");

    a_abs_offset: assert property (@(posedge clk) disable iff (!resetn)
        (abs_code == 4'hF) |=> (settings.abs_db == 7'(target_db_of($past(target_code)) - 7'h01)))
        else $error("Absolute code -1 is not 1 dB below target.");

    a_top_bit_zero: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_read && cfg_addr == PRIORITY_SENSE_ADDR) |=> (cfg_rdata[7] == 1'h0))
        else $error("Unused top bit read back as one.");

    a_step_limit_top: assert property (@(posedge clk) disable iff (!resetn)
        (dgain_limit == 2'h3) |=> (settings.dgain_step_max == DIGITAL_GAIN_TOP_STEP - 3'h3))
        else $error("Limit three did not bar the three highest digital steps.");

    a_fe_cap_low: assert property (@(posedge clk) disable iff (!resetn)
        (fe_cap_code == 3'h1) |=> (settings.fe_cap_tenth_db == 8'h1A))
        else $error("Cap code one is not 2.6 dB below maximum.");

    a_fe_cap_mid: assert property (@(posedge clk) disable iff (!resetn)
        (fe_cap_code == 3'h4) |=> (settings.fe_cap_tenth_db == 8'h5C))
        else $error("Cap code four is not 9.2 dB below maximum.");

    a_fe_cap_six: assert property (@(posedge clk) disable iff (!resetn)
        (fe_cap_code == 3'h6) |=> (settings.fe_cap_tenth_db == 8'h92))
        else $error("Cap code six is not 14.6 dB below maximum.");

    a_target_low: assert property (@(posedge clk) disable iff (!resetn)
        (target_code == 3'h0) |=> (settings.target_db == 7'h18))
        else $error("Target code zero is not 24 dB.");

    a_target_top: assert property (@(posedge clk) disable iff (!resetn)
        (target_code == 3'h7) |=> (settings.target_db == 7'h2A))
        else $error("Target code seven is not 42 dB.");

    a_rel_off: assert property (@(posedge clk) disable iff (!resetn)
        (rel_code == 2'h0) |=> !settings.rel_enable)
        else $error("Relative code zero left relative sensing on.");

    a_rel_low: assert property (@(posedge clk) disable iff (!resetn)
        (rel_code == 2'h1) |=> (settings.rel_enable && settings.rel_db == 4'h6))
        else $error("Relative code one is not a 6 dB rise.");

    a_rel_top: assert property (@(posedge clk) disable iff (!resetn)
        (rel_code == 2'h3) |=> (settings.rel_enable && settings.rel_db == 4'hE))
        else $error("Relative code three is not a 14 dB rise.");

    a_abs_at_target: assert property (@(posedge clk) disable iff (!resetn)
        (abs_code == 4'h0) |=> (settings.abs_enable && settings.abs_db == target_db_of($past(target_code))))
        else $error("Absolute code zero is not at the target.");

    a_abs_top: assert property (@(posedge clk) disable iff (!resetn)
        (abs_code == 4'h7) |=> (settings.abs_db == 7'(target_db_of($past(target_code)) + 7'h07)))
        else $error("Absolute code 7 is not 7 dB above target.");

    a_abs_bottom: assert property (@(posedge clk) disable iff (!resetn)
        (abs_code == 4'h9) |=> (settings.abs_enable && settings.abs_db == 7'(target_db_of($past(target_code)) - 7'h07)))
        else $error("Absolute code -7 is not 7 dB below target.");

    a_limit_readback: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_read && cfg_addr == GAIN_LIMIT_TARGET_ADDR) |=> (cfg_rdata == $past(limit_target_reg)))
        else $error("Gain-limit register did not read back as held.");

    a_sense_readback: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_read && cfg_addr == PRIORITY_SENSE_ADDR) |=> (cfg_rdata[6:0] == $past(priority_sense_reg)))
        else $error("Sense register did not read back as held.");

    a_stray_write: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_write && cfg_addr != GAIN_LIMIT_TARGET_ADDR && cfg_addr != PRIORITY_SENSE_ADDR)
        |=> ($stable(limit_target_reg) && $stable(priority_sense_reg)))
        else $error("A write to an unmapped address changed a register.");

    a_stray_read_zero: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_read && cfg_addr != GAIN_LIMIT_TARGET_ADDR && cfg_addr != PRIORITY_SENSE_ADDR)
        |=> (cfg_rdata == 8'h00))
        else $error("A read of an unmapped address did not return zero.");

    a_settings_hold: assert property (@(posedge clk) disable iff (!resetn)
        (!cfg_write) |=> ##1 $stable(settings))
        else $error("Settings moved without a register write.");

endmodule : agc_gain_limit_carrier_sense_cfg

// ### testbench/agc_gain_limit_carrier_sense_cfg_tb.sv
// Self-checking bench for the gain-limit, target and carrier-sense configuration block.
`timescale 1ns/1ps
module agc_gain_limit_carrier_sense_cfg_tb;
    import agc_cfg_pkg::*;
    logic clk;
    logic resetn;
    logic cfg_write;
    logic cfg_read;
    logic carrier_sense;
    logic [5:0] cfg_addr;
    logic [7:0] cfg_wdata;
    logic [7:0] cfg_rdata;
    logic [6:0] filter_amp_db;
    logic [6:0] gain_reduction_db;
    logic [6:0] strength_rise_db;
    settings_type settings;
    int failures;
    int check_count;
    int cycles;
    logic [6:0] tgt [8] = '{7'h18, 7'h1B, 7'h1E, 7'h21, 7'h24, 7'h26, 7'h28, 7'h2A};
    logic [7:0] cap [8] = '{8'h00, 8'h1A, 8'h3D, 8'h4A, 8'h5C, 8'h73, 8'h92, 8'hAB};
    logic [3:0] rel [4] = '{4'h0, 4'h6, 4'hA, 4'hE};

    agc_gain_limit_carrier_sense_cfg DUT (
        .clk(clk), .resetn(resetn), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_rdata(cfg_rdata),
        .filter_amp_db(filter_amp_db), .gain_reduction_db(gain_reduction_db),
        .strength_rise_db(strength_rise_db), .settings(settings), .carrier_sense(carrier_sense)
    );

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // The whole sequence needs well under a thousand cycles, so this only trips on a hang.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Settings follow a write two edges later, so two extra cycles pass before returning.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_write = 1'h1;
        @(negedge clk);
        cfg_write = 1'h0;
        repeat (2) @(negedge clk);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(negedge clk);
        cfg_addr = a;
        cfg_read = 1'h1;
        @(negedge clk);
        cfg_read = 1'h0;
        check(cfg_rdata, exp);
    endtask : rd

    task automatic sense(input logic [6:0] amp, input logic [6:0] red, input logic [6:0] rise, input logic exp);
        @(negedge clk);
        filter_amp_db = amp;
        gain_reduction_db = red;
        strength_rise_db = rise;
        repeat (2) @(negedge clk);
        check({7'h00, carrier_sense}, {7'h00, exp});
    endtask : sense

    initial begin
        logic [2:0] c;
        logic [1:0] r;
        logic [3:0] k;
        failures = 0;
        check_count = 0;
        cycles = 0;
        resetn = 1'h0;
        cfg_write = 1'h0;
        cfg_read = 1'h0;
        cfg_addr = 6'h00;
        cfg_wdata = 8'h00;
        filter_amp_db = 7'h00;
        gain_reduction_db = 7'h00;
        strength_rise_db = 7'h00;
        repeat (12) @(negedge clk);
        resetn = 1'h1;
        repeat (2) @(negedge clk);
        rd(6'h1B, 8'h03);
        rd(6'h1C, 8'h40);
        check(8'(settings.dgain_step_max), 8'(DIGITAL_GAIN_TOP_STEP));
        check(settings.fe_cap_tenth_db, 8'h00);
        check(8'(settings.target_db), 8'h21);
        check(8'(settings.reduce_first_amp_first), 8'h01);
        check(8'(settings.rel_enable), 8'h00);
        check({settings.abs_enable, settings.abs_db}, 8'hA1);
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(6'h1B, {c[1:0], c, c});
            rd(6'h1B, {c[1:0], c, c});
            check(8'(settings.dgain_step_max), 8'(3'(DIGITAL_GAIN_TOP_STEP - 3'(c[1:0]))));
            check(settings.fe_cap_tenth_db, cap[i]);
            check(8'(settings.target_db), 8'(tgt[i]));
        end
        wr(6'h1B, 8'h03);
        for (int j = 0; j < 4; j++) begin
            r = 2'(j);
            wr(6'h1C, {2'h2, r, 4'h8});
            rd(6'h1C, {2'h0, r, 4'h8});
            check(8'(settings.reduce_first_amp_first), 8'h00);
            check({3'h0, settings.rel_enable, settings.rel_db}, {3'h0, r != 2'h0, rel[j]});
        end
        for (int n = 0; n < 16; n++) begin
            k = 4'(n);
            wr(6'h1C, {4'h4, k});
            check(8'(settings.abs_enable), 8'(k != 4'h8));
            if (k != 4'h8)
                check(8'(settings.abs_db), 8'(7'(tgt[3] + {{3{k[3]}}, k})));
        end
        check(8'(settings.reduce_first_amp_first), 8'h01);
        // The absolute threshold must move with the target, not sit at a fixed level.
        wr(6'h1B, 8'h07);
        wr(6'h1C, 8'h4F);
        check({settings.abs_enable, settings.abs_db}, {1'h1, 7'(tgt[7] - 7'h01)});
        sense(7'h29, 7'h00, 7'h00, 1'h1);
        sense(7'h27, 7'h01, 7'h00, 1'h0);
        wr(6'h1B, 8'h03);
        wr(6'h1D, 8'hFF);
        rd(6'h1D, 8'h00);
        rd(6'h1B, 8'h03);
        wr(6'h1C, 8'h40);
        sense(7'h1E, 7'h03, 7'h00, 1'h1);
        sense(7'h1E, 7'h02, 7'h00, 1'h0);
        sense(7'h14, 7'h00, 7'h14, 1'h0);
        wr(6'h1C, 8'h58);
        sense(7'h3C, 7'h00, 7'h06, 1'h1);
        sense(7'h3C, 7'h00, 7'h05, 1'h0);
        wr(6'h1C, 8'h48);
        sense(7'h3C, 7'h00, 7'h14, 1'h0);
        stop_test();
    end
endmodule : agc_gain_limit_carrier_sense_cfg_tb
